// ==== rtl/tdo_pkg.sv ====
// Shared constants and types of the TDM output timing and drive block
package tdo_pkg;
   // =====================================================
   // Timebase: one tick is a rising edge of the link timing clock
   // =====================================================
   localparam int TICK_KHZ     = 65536;              // Nominal timing clock rate
   localparam int TICK_PS      = 15259;              // One tick, rounded to ps
   localparam int FRAME_HZ     = 8000;               // Frame repetition rate
   localparam int CNT_W        = 13;
   localparam int FRAME_TICKS  = TICK_KHZ * 1000 / FRAME_HZ;
   localparam logic [12:0] CNT_RST = 13'h0000;       // Counter value after reset
   localparam logic [12:0] CNT_MAX = 13'(FRAME_TICKS - 1);
   // =====================================================
   // Frame clock outputs: rates in kHz, tap of the tick counter
   // =====================================================
   localparam int CLK_A_SLOW_KHZ = 4094;
   localparam int CLK_A_FAST_KHZ = 8192;
   localparam int CLK_B_SLOW_KHZ = 8192;
   localparam int CLK_B_FAST_KHZ = 16384;
   localparam int CLK_C_SLOW_KHZ = 16384;
   localparam int CLK_C_FAST_KHZ = 32768;
   localparam int TAP_A_SLOW = $clog2(TICK_KHZ / CLK_A_SLOW_KHZ) - 1;
   localparam int TAP_A_FAST = $clog2(TICK_KHZ / CLK_A_FAST_KHZ) - 1;
   localparam int TAP_B_SLOW = $clog2(TICK_KHZ / CLK_B_SLOW_KHZ) - 1;
   localparam int TAP_B_FAST = $clog2(TICK_KHZ / CLK_B_FAST_KHZ) - 1;
   localparam int TAP_C_SLOW = $clog2(TICK_KHZ / CLK_C_SLOW_KHZ) - 1;
   localparam int TAP_C_FAST = $clog2(TICK_KHZ / CLK_C_FAST_KHZ) - 1;
   // =====================================================
   // Frame pulse widths in ns, then half widths in ticks
   // =====================================================
   localparam int PB_SHORT_NS = 61;
   localparam int PB_WIDE_NS  = 122;
   localparam int PC_SHORT_NS = 30;
   localparam int PC_WIDE_NS  = 61;
   localparam logic [12:0] PB_SHORT_HALF = 13'((PB_SHORT_NS * 1000 + TICK_PS / 2) / TICK_PS / 2);
   localparam logic [12:0] PB_WIDE_HALF  = 13'((PB_WIDE_NS * 1000 + TICK_PS / 2) / TICK_PS / 2);
   localparam logic [12:0] PC_SHORT_HALF = 13'((PC_SHORT_NS * 1000 + TICK_PS / 2) / TICK_PS / 2);
   localparam logic [12:0] PC_WIDE_HALF  = 13'((PC_WIDE_NS * 1000 + TICK_PS / 2) / TICK_PS / 2);
   // =====================================================
   // Serial streams
   // =====================================================
   localparam int STREAMS    = 16;
   localparam int SLOTS_2M   = 32;
   localparam int SLOTS_4M   = 64;
   localparam int SLOTS_8M   = 128;
   localparam int SLOT_LOG_2M = $clog2(FRAME_TICKS / SLOTS_2M);
   localparam int SLOT_LOG_4M = $clog2(FRAME_TICKS / SLOTS_4M);
   localparam int SLOT_LOG_8M = $clog2(FRAME_TICKS / SLOTS_8M);
   localparam int SLOT_BITS  = 8;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;         // Sent when the FIFO runs dry
   // Slot word: byte of stream i at [8i+7:8i], its high-impedance flag at HIZ_LSB+i
   localparam int HIZ_LSB    = STREAMS * SLOT_BITS;
   localparam int WORD_W     = HIZ_LSB + STREAMS;
   localparam int FIFO_DEPTH = 16;
   typedef enum logic [1:0] {RATE_2M, RATE_4M, RATE_8M, RATE_RSVD} tdo_rate_e;
endpackage : tdo_pkg

// ==== rtl/tdo_sync.sv ====
// Two-stage synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module tdo_sync (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // Level in and out
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_r;

   // =====================================================
   // Synchroniser chain; the first stage feeds only the second
   // =====================================================
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_r   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule : tdo_sync
`default_nettype wire

// ==== rtl/tdo_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tdo_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rst_n,
   // Fill side
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   // Drain side
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  wptr_r;
   logic [AW:0]  rptr_r;
   logic         full;
   logic         empty;
   logic         push;
   logic         pop;

   // Extra pointer bit tells full from empty
   assign empty     = (wptr_r == rptr_r);
   assign full      = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign push      = in_valid && !full;
   assign pop       = out_ready && !empty;
   assign out_data  = mem[rptr_r[AW-1:0]];

   // Storage has no reset; only words behind valid are ever read
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wptr_r[AW-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wptr_r <= '0;
         rptr_r <= '0;
      end else begin
         if (push) wptr_r <= wptr_r + 1'b1;
         if (pop)  rptr_r <= rptr_r + 1'b1;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_fifo_no_overrun: assert property (full && !pop |=> wptr_r == $past(wptr_r))
      else $error("FIFO pointer moved while full");
   a_fifo_fill_limit: assert property ((AW+1)'(wptr_r - rptr_r) <= (AW+1)'(D))
      else $error("FIFO holds more words than its depth");
endmodule : tdo_fifo
`default_nettype wire

// ==== rtl/tdo_output_timing.sv ====
// TDM output timing and drive: frame clocks, frame pulses and sixteen serial streams
// Function
// - Clock A runs at 4.096 or 8.192 MHz by its rate select.
// - Clock B runs at 16.384 or 8.192 MHz by its rate select.
// - Clock C runs at 32.768 or 16.384 MHz by its rate select.
// - In default polarity each frame clock falls exactly at the frame boundary.
// - Pulse B is low 61 ns or 122 ns around each frame boundary.
// - Pulse C is low 30 ns or 61 ns around each frame boundary.
// - Every frame pulse occurs once per frame, 8 kHz.
// - A set polarity bit inverts its frame clock or frame pulse.
// - The drive gate acts on the outputs with no clock in the path.
// - Gate high: streams and buffer controls operate normally.
// - Gate low: streams float, every buffer control is driven high.
// - Each stream has its own rate select, applied to that stream.
// - At 2.048 Mbps a stream carries 32 slots per frame.
// - At 4.096 Mbps a stream carries 64 slots per frame.
// - At 8.192 Mbps a stream carries 128 slots per frame.
// - Buffer control is high for a floating slot, low for an active one.
`timescale 1ns/1ps
`default_nettype none
module tdo_output_timing (
   // Clock and reset
   input  wire logic                       clock,
   input  wire logic                       rst_n,
   // Link timing clock, from outside this domain
   input  wire logic                       timing_clock,
   // Frame clock and pulse configuration
   input  wire logic                       clk_a_fast,
   input  wire logic                       clk_b_fast,
   input  wire logic                       clk_c_fast,
   input  wire logic                       pulse_b_wide,
   input  wire logic                       pulse_c_wide,
   input  wire logic [4:0]                 polarity_invert,
   // Per-stream rate select, two bits per stream
   input  wire logic [31:0]                stream_rate,
   // Slot words from the switching core
   input  wire logic [tdo_pkg::WORD_W-1:0] slot_word_data,
   input  wire logic                       slot_word_valid,
   output logic                            slot_word_ready,
   // Frame clocks and pulses
   output logic                            frame_clock_out_a,
   output logic                            frame_clock_out_b,
   output logic                            frame_clock_out_c,
   output logic                            frame_pulse_out_b,
   output logic                            frame_pulse_out_c,
   // Serial streams and external buffer control
   input  wire logic                       serial_drive_gate,
   output logic [15:0]                     serial_out_stream,
   output logic [15:0]                     serial_out_stream_oe,
   output logic [15:0]                     external_buffer_ctrl,
   // Status
   output logic                            frame_start,
   output logic                            slot_underrun
);
   // =====================================================
   // Declarations
   // =====================================================
   logic                        tclk_s;
   logic                        tclk_d_r;
   logic                        tick;
   logic [12:0]                 cnt_r;
   logic                        slot_edge;
   logic [tdo_pkg::WORD_W-1:0]  fifo_data;
   logic                        fifo_valid;
   logic [15:0]                 hiz_r;
   logic [15:0]                 load;
   logic [12:0]                 half_b;
   logic [12:0]                 half_c;
   logic                        pulse_b_win;
   logic                        pulse_c_win;

   // =====================================================
   // Link timing clock: synchronise, then find rising edges
   // =====================================================
   tdo_sync u_tclk_sync (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in (timing_clock),
      .sync_out (tclk_s)
   );

   // Delayed copy of the synchronised level for edge finding
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tclk_d_r <= 1'b0;
      end else begin
         tclk_d_r <= tclk_s;
      end
   end

   assign tick = tclk_s && !tclk_d_r;

   // =====================================================
   // Frame counter: one frame of ticks, wraps at the boundary
   // =====================================================
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= tdo_pkg::CNT_RST;
      end else if (tick) begin
         cnt_r <= (cnt_r == tdo_pkg::CNT_MAX) ? 13'h0000 : cnt_r + 13'h0001;
      end
   end

   // Boundary marker for the status port
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         frame_start <= 1'b0;
      end else begin
         frame_start <= tick && (cnt_r == tdo_pkg::CNT_MAX);
      end
   end

   // =====================================================
   // Frame clocks: a counter tap, so every clock is low right after the wrap unless its polarity bit is set
   // =====================================================
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         frame_clock_out_a <= 1'b0;
         frame_clock_out_b <= 1'b0;
         frame_clock_out_c <= 1'b0;
      end else begin
         // The 4.094 figure taps the same divider as 4.096; the tick rate cannot give it exactly
         frame_clock_out_a <= (clk_a_fast ? cnt_r[tdo_pkg::TAP_A_FAST] : cnt_r[tdo_pkg::TAP_A_SLOW])
                              ^ polarity_invert[0];
         frame_clock_out_b <= (clk_b_fast ? cnt_r[tdo_pkg::TAP_B_FAST] : cnt_r[tdo_pkg::TAP_B_SLOW])
                              ^ polarity_invert[1];
         frame_clock_out_c <= (clk_c_fast ? cnt_r[tdo_pkg::TAP_C_FAST] : cnt_r[tdo_pkg::TAP_C_SLOW])
                              ^ polarity_invert[2];
      end
   end

   // =====================================================
   // Frame pulses: low window straddles the boundary, half each side
   // =====================================================
   assign half_b      = pulse_b_wide ? tdo_pkg::PB_WIDE_HALF : tdo_pkg::PB_SHORT_HALF;
   assign half_c      = pulse_c_wide ? tdo_pkg::PC_WIDE_HALF : tdo_pkg::PC_SHORT_HALF;
   assign pulse_b_win = (cnt_r < half_b) || (cnt_r > 13'(tdo_pkg::CNT_MAX - half_b));
   assign pulse_c_win = (cnt_r < half_c) || (cnt_r > 13'(tdo_pkg::CNT_MAX - half_c));

   // Pulse outputs, active low unless inverted
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         frame_pulse_out_b <= 1'b1;
         frame_pulse_out_c <= 1'b1;
      end else begin
         frame_pulse_out_b <= !pulse_b_win ^ polarity_invert[3];
         frame_pulse_out_c <= !pulse_c_win ^ polarity_invert[4];
      end
   end

   // =====================================================
   // Slot word FIFO: one word per fastest slot, popped just before it starts
   // =====================================================
   assign slot_edge = tick && (cnt_r[tdo_pkg::SLOT_LOG_8M-1:0] == '1);

   tdo_fifo #(
      .W (tdo_pkg::WORD_W),
      .D (tdo_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_data   (slot_word_data),
      .in_valid  (slot_word_valid),
      .in_ready  (slot_word_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (slot_edge)
   );

   // Empty FIFO at a slot start: streams send idle and float instead of stale data
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         slot_underrun <= 1'b0;
      end else begin
         slot_underrun <= slot_edge && !fifo_valid;
      end
   end

   // =====================================================
   // Per-stream serialisers
   // =====================================================
   genvar gi;
   generate
      for (gi = 0; gi < tdo_pkg::STREAMS; gi++) begin : g_stream
         logic [12:0]        slot_mask;
         logic [12:0]        bit_mask;
         logic [7:0]         shift_r;
         logic               bit_edge;
         tdo_pkg::tdo_rate_e rate;

         assign rate = tdo_pkg::tdo_rate_e'(stream_rate[2*gi +: 2]);

         // Slot and bit lengths from the stream's own rate; reserved code runs as 2.048
         always_comb begin
            case (rate)
               tdo_pkg::RATE_8M: slot_mask = 13'((1 << tdo_pkg::SLOT_LOG_8M) - 1);
               tdo_pkg::RATE_4M: slot_mask = 13'((1 << tdo_pkg::SLOT_LOG_4M) - 1);
               default:          slot_mask = 13'((1 << tdo_pkg::SLOT_LOG_2M) - 1);
            endcase
         end

         assign bit_mask = slot_mask >> 3;
         assign load[gi] = slot_edge && ((cnt_r & slot_mask) == slot_mask);
         assign bit_edge = tick && ((cnt_r & bit_mask) == bit_mask);

         // Load a byte at the slot start, then shift left once per bit period
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               shift_r   <= tdo_pkg::IDLE_BYTE;
               hiz_r[gi] <= 1'b1;
            end else if (load[gi]) begin
               shift_r   <= fifo_valid ? fifo_data[8*gi +: 8] : tdo_pkg::IDLE_BYTE;
               hiz_r[gi] <= fifo_valid ? fifo_data[tdo_pkg::HIZ_LSB + gi] : 1'b1;
            end else if (bit_edge) begin
               shift_r   <= {shift_r[6:0], 1'b1};
            end
         end

         assign serial_out_stream[gi] = shift_r[7];
      end
   endgenerate

   // =====================================================
   // Drive gate: straight to the pins, so it needs no clock
   // =====================================================
   assign serial_out_stream_oe = {16{serial_drive_gate}} & ~hiz_r;
   assign external_buffer_ctrl = {16{!serial_drive_gate}} | hiz_r;

   // =====================================================
   // Assertions
   // =====================================================
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_wrap;
      tick && (cnt_r == tdo_pkg::CNT_MAX) ##1 (cnt_r == 13'h0000);
   endsequence

   sequence s_wrap_8m_stream0;
      (load[0] && fifo_valid && (stream_rate[1:0] == 2'h2)) ##1 (cnt_r[5:0] == 6'h00);
   endsequence

   a_frame_wrap_once: assert property (tick && cnt_r == tdo_pkg::CNT_MAX |=> cnt_r == 13'h0000 && frame_start)
      else $error("Frame counter did not wrap at the end of the frame");

   a_frame_start_once: assert property (frame_start |=> !frame_start)
      else $error("Frame start marker stood for more than a cycle");

   a_clk_a_fall: assert property (s_wrap and $stable(polarity_invert)
                                  |=> frame_clock_out_a == polarity_invert[0])
      else $error("Clock A not at its low phase after the boundary");

   a_clk_b_fall: assert property (s_wrap and $stable(polarity_invert)
                                  |=> frame_clock_out_b == polarity_invert[1])
      else $error("Clock B not at its low phase after the boundary");

   a_clk_c_fall: assert property (s_wrap and $stable(polarity_invert)
                                  |=> frame_clock_out_c == polarity_invert[2])
      else $error("Clock C not at its low phase after the boundary");

   a_pulse_b_start: assert property (cnt_r == 13'h0000 && !polarity_invert[3] |=> !frame_pulse_out_b)
      else $error("Pulse B not low at the boundary");

   a_pulse_c_start: assert property (cnt_r == 13'h0000 && !polarity_invert[4] |=> !frame_pulse_out_c)
      else $error("Pulse C not low at the boundary");

   a_pulse_b_end: assert property (cnt_r == tdo_pkg::PB_SHORT_HALF && !pulse_b_wide && !polarity_invert[3]
                                   |=> frame_pulse_out_b)
      else $error("Short pulse B too long");

   a_pulse_b_wide: assert property (cnt_r == tdo_pkg::PB_WIDE_HALF && pulse_b_wide && !polarity_invert[3]
                                    |=> frame_pulse_out_b)
      else $error("Wide pulse B too long");

   a_pulse_c_end: assert property (cnt_r == tdo_pkg::PC_WIDE_HALF && pulse_c_wide && !polarity_invert[4]
                                   |=> frame_pulse_out_c)
      else $error("Wide pulse C too long");

   a_pulse_c_short: assert property (cnt_r == tdo_pkg::PC_SHORT_HALF && !pulse_c_wide && !polarity_invert[4]
                                     |=> frame_pulse_out_c)
      else $error("Short pulse C too long");

   a_gate_low_float: assert property (!serial_drive_gate |-> serial_out_stream_oe == 16'h0000
                                      && external_buffer_ctrl == 16'hFFFF)
      else $error("Streams driven while the gate is low");

   a_gate_high_ctrl: assert property (serial_drive_gate |-> external_buffer_ctrl == hiz_r
                                      && serial_out_stream_oe == ~hiz_r)
      else $error("Buffer control disagrees with slot state");

   a_underrun_float: assert property (slot_underrun && stream_rate[1:0] == 2'h2
                                      |-> hiz_r[0] && serial_out_stream[0])
      else $error("Stream 0 not floating after an underrun");

   a_load_2m_spacing: assert property (load[15] && stream_rate[31:30] == 2'h0 |-> cnt_r[7:0] == 8'hFF)
      else $error("Stream 15 loaded off a 2.048 slot start");

   a_load_4m_spacing: assert property (load[1] && stream_rate[3:2] == 2'h1 |-> cnt_r[6:0] == 7'h7F)
      else $error("Stream 1 loaded off a 4.096 slot start");

   a_msb_first_out: assert property (s_wrap_8m_stream0
                                     |-> serial_out_stream[0] == $past(fifo_data[7], 1))
      else $error("Stream 0 did not start its slot with the top bit");
endmodule : tdo_output_timing
`default_nettype wire

// ==== verif/tdo_downstream.sv ====
// Downstream TDM receiver model: resolves the stream wires and captures bytes on clock A
`timescale 1ns/1ps
`default_nettype none
module tdo_downstream (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rst_n,
   // Pins from the block
   input  wire logic         frame_clock_out_a,
   input  wire logic [15:0]  serial_out_stream,
   input  wire logic [15:0]  serial_out_stream_oe,
   // Last eight bits seen on each stream, newest in bit 0
   output logic      [127:0] captured
);
   // =====================================================
   // Wire level
   // =====================================================
   logic [15:0] line;
   logic [15:0] last_r;
   logic        clk_a_d_r;
   // A floating line shows the inverse of its last level, so a stale copy cannot pass as data
   assign line = (serial_out_stream & serial_out_stream_oe) | (~last_r & ~serial_out_stream_oe);
   // Last level memory
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) last_r <= 16'h0000;
      else last_r <= line;
   end
   // Sample mid-bit on the rise of clock A, whose fall marks each bit boundary
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         clk_a_d_r <= 1'b0;
         captured  <= '0;
      end else begin
         clk_a_d_r <= frame_clock_out_a;
         if (frame_clock_out_a && !clk_a_d_r) begin
            for (int i = 0; i < 16; i++) begin
               captured[8*i +: 8] <= {captured[8*i +: 7], line[i]};
            end
         end
      end
   end
endmodule : tdo_downstream
`default_nettype wire

// ==== verif/tdo_output_timing_bench.sv ====
// Self-checking bench of the TDM output timing and drive block
`timescale 1ns/1ps
`default_nettype none
module tdo_output_timing_bench;
   // =====================================================
   // Stimulus and observed signals
   // =====================================================
   logic                       clock = 1'b0, rst_n = 1'b0, timing_clock = 1'b0;
   logic                       clk_a_fast = 1'b1, clk_b_fast = 1'b1, clk_c_fast = 1'b1;
   logic                       pulse_b_wide = 1'b0, pulse_c_wide = 1'b0, serial_drive_gate = 1'b1;
   logic [4:0]                 polarity_invert = 5'h00;
   logic [31:0]                stream_rate = 32'hAAAAAAAA;
   logic [tdo_pkg::WORD_W-1:0] slot_word_data = '0;
   logic                       slot_word_valid = 1'b0;
   logic                       slot_word_ready, ck_a, ck_b, ck_c, fp_b, fp_c, frame_start, slot_underrun;
   logic [15:0]                sout, sout_oe, ebc;
   logic [127:0]               captured;
   int                         n_errors = 0, samples_checked = 0;
   // Main clock at 100 MHz; link clock 160 ns, offset so it never lands on a sampling edge
   always #5 clock = ~clock;
   initial begin
      #3;
      forever #80 timing_clock = ~timing_clock;
   end
   tdo_output_timing tdo_output_timing_i (.clock(clock), .rst_n(rst_n), .timing_clock(timing_clock),
      .clk_a_fast(clk_a_fast), .clk_b_fast(clk_b_fast), .clk_c_fast(clk_c_fast),
      .pulse_b_wide(pulse_b_wide), .pulse_c_wide(pulse_c_wide), .polarity_invert(polarity_invert),
      .stream_rate(stream_rate), .slot_word_data(slot_word_data), .slot_word_valid(slot_word_valid),
      .slot_word_ready(slot_word_ready), .frame_clock_out_a(ck_a), .frame_clock_out_b(ck_b),
      .frame_clock_out_c(ck_c), .frame_pulse_out_b(fp_b), .frame_pulse_out_c(fp_c),
      .serial_drive_gate(serial_drive_gate), .serial_out_stream(sout), .serial_out_stream_oe(sout_oe),
      .external_buffer_ctrl(ebc), .frame_start(frame_start), .slot_underrun(slot_underrun));
   tdo_downstream tdo_downstream_i (.clock(clock), .rst_n(rst_n), .frame_clock_out_a(ck_a),
      .serial_out_stream(sout), .serial_out_stream_oe(sout_oe), .captured(captured));
   // =====================================================
   // Shared tasks
   // =====================================================
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : check
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   function automatic logic pick(input int k);
      case (k)
         0: pick = ck_a;
         1: pick = ck_b;
         2: pick = ck_c;
         3: pick = fp_b;
         4: pick = fp_c;
         5: pick = slot_underrun;
         default: pick = sout_oe[0];
      endcase
   endfunction : pick
   // Bounded wait for a level; a wait that runs out ends the run
   task automatic wait_lvl(input int k, input logic lvl, input int bound, output int n);
      n = 0;
      while (pick(k) !== lvl) begin
         @(posedge clock);
         n++;
         if (n > bound) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, pick(k), lvl);
            results();
         end
      end
   endtask : wait_lvl
   // Reset for 16 cycles, released just after a link clock fall so the first tick lands at a known time
   task automatic do_reset();
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (16) @(posedge clock);
      check({sout_oe, ebc, slot_word_ready}, {16'h0000, 16'hFFFF, 1'b1});
      @(negedge timing_clock);
      @(posedge clock);
      rst_n <= 1'b1;
   endtask : do_reset
   // =====================================================
   // Scenarios
   // =====================================================
   // Levels at the frame start and pulse widths after reset, in both polarities
   task automatic t_pulse(input logic inv);
      int nc, nb;
      polarity_invert <= {5{inv}};
      pulse_b_wide    <= ~inv;
      pulse_c_wide    <= ~inv;
      do_reset();
      repeat (5) @(posedge clock);
      check({ck_a, ck_b, ck_c}, {3{inv}});
      wait_lvl(4, ~inv, 400, nc);
      wait_lvl(3, ~inv, 400, nb);
      check((nc + 13) / 16, inv ? 1 : 2);
      check((nc + nb + 13) / 16, inv ? 2 : 4);
      repeat (300) @(posedge clock);
      check({fp_b, fp_c}, {2{~inv}});
      $display("Test pulse polarity %0d done", inv);
   endtask : t_pulse
   // High time of each frame clock in system cycles, both rate selects
   task automatic t_clocks();
      int n;
      polarity_invert <= 5'h00;
      do_reset();
      for (int f = 0; f < 2; f++) begin
         {clk_a_fast, clk_b_fast, clk_c_fast} <= {3{f[0]}};
         for (int k = 0; k < 3; k++) begin
            wait_lvl(k, 1'b1, 600, n);
            wait_lvl(k, 1'b0, 600, n);
            wait_lvl(k, 1'b1, 600, n);
            wait_lvl(k, 1'b0, 600, n);
            check(n, (128 >> k) >> f);
         end
      end
      $display("Test frame clocks done");
   endtask : t_clocks
   // Fill the FIFO until it refuses, send one slot, gate the drive, then drain to underrun
   task automatic t_stream();
      logic [tdo_pkg::WORD_W-1:0] w;
      logic [119:0]               exp;
      int                         acc, n;
      w   = '0;
      acc = 0;
      for (int i = 0; i < 16; i++) begin
         w[8*i +: 8] = {4'(i), ~4'(i)};
      end
      w[tdo_pkg::HIZ_LSB + 15] = 1'b1;
      exp = w[119:0];
      exp[15:8] = {{2{w[15]}}, {2{w[14]}}, {2{w[13]}}, {2{w[12]}}}; // Stream 1 at 4.096: each bit seen twice
      {clk_a_fast, polarity_invert} <= {1'b1, 5'h00};
      stream_rate <= 32'h2AAAAAA6;
      do_reset();
      slot_word_data  <= w;
      slot_word_valid <= 1'b1;
      repeat (20) begin
         @(negedge clock);
         acc += int'(slot_word_ready === 1'b1);
         @(posedge clock);
      end
      slot_word_valid <= 1'b0;
      check(acc, 16);
      check(slot_word_ready, 1'b0);
      wait_lvl(6, 1'b1, 1500, n);
      serial_drive_gate <= 1'b0;
      #1 check({sout_oe, ebc}, {16'h0000, 16'hFFFF});
      @(posedge clock);
      serial_drive_gate <= 1'b1;
      #1 check({sout_oe[15], sout_oe[1:0], ebc[15], ebc[0]}, 5'b00110);
      repeat (2009) @(posedge clock);
      check(captured[119:0], exp);
      wait_lvl(5, 1'b1, 20000, n);
      repeat (3) @(posedge clock);
      check({ebc[0], sout_oe[0], slot_word_ready}, 3'b101);
      $display("Test streams and FIFO done");
   endtask : t_stream
   // =====================================================
   // Main sequence
   // =====================================================
   initial begin
      t_pulse(1'b0);
      t_pulse(1'b1);
      t_clocks();
      t_stream();
      results();
   end
endmodule : tdo_output_timing_bench
`default_nettype wire
